// ===== design/lcp_pkg.sv
// constants for the serial pattern output block
package lcp_pkg;
  // ----------------------------------------
  // serial programming frame
  // ----------------------------------------
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 16;
  localparam int FRAME_BITS = 24;
  localparam int CODE_W     = 12;
  localparam int LANE_BITS  = 6;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0]  REG_SOFT_RESET = 8'h00;
  localparam logic [7:0]  REG_DITHER     = 8'h01;
  localparam logic [7:0]  REG_PAT_MODE   = 8'h25;
  localparam logic [7:0]  REG_CODE1_LO   = 8'h26;
  localparam logic [7:0]  REG_CODE2_LO   = 8'h27;
  localparam int          SOFT_RESET_BIT = 0;
  localparam int          DITHER_BIT     = 0;
  localparam int          TWO_CODE_BIT   = 5;
  localparam int          FIXED_CODE_BIT = 4;
  localparam int          CODE1_MSB_POS  = 0;
  localparam int          CODE2_MSB_POS  = 2;
  localparam int          CODE_LO_POS    = 6;
  localparam logic [15:0] DITHER_RESET   = 16'h0001;
  localparam logic [15:0] PAT_RESET      = 16'h0000;
  localparam logic [15:0] CODE_RESET     = 16'h0000;
  // ----------------------------------------
  // serializer states
  // ----------------------------------------
  typedef enum logic {
    LCP_IDLE  = 1'b0,
    LCP_SHIFT = 1'b1
  } lcp_ser_state_t;
endpackage

// ===== design/lcp_pattern_out.sv
// serial sample output with pattern generator, dither and sleep control
// Operation
// RULE1: first positive bit-clock edge after a sample-clock rise is falling
// RULE2: bit clock pair is inverted, a half-period phase shift
// RULE3: receiver without deskew should accept either bit-clock polarity
// RULE4: receiver must not assume a fixed sample-to-output latency
// RULE5: sleep pin puts every channel into full power-down
// RULE6: dither is on after power-up and reset
// RULE7: dither can be switched off by a serial register write
// RULE8: reset command restores register defaults, dither on included
// RULE9: two-code bit set, fixed bit clear: output alternates both codes
// RULE10: fixed bit set, two-code bit clear: output first code always
// RULE11: codes are 12 bits, bit 11 msb; first code is fixed code
// RULE12: register 25 holds code msbs, first in D1:D0, second D3:D2
// RULE13: register 26 holds first code low ten bits in D15:D6
// RULE14: register 27 holds second code low ten bits in D15:D6
// RULE15: software writes codes using these bit positions
// RULE16: after reset both pattern bits clear, normal data flows
`timescale 1ns/1ns
module lcp_pattern_out
  import lcp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        sample_clock_pos,
  input  wire logic        sleep_pin,
  input  wire logic        spi_clk,
  input  wire logic        spi_data,
  input  wire logic        spi_en_n,
  input  wire logic [11:0] adc_data,
  input  wire logic        adc_valid,
  output logic             core_ready_q,
  output logic             bit_clock_pos_q,
  output logic             bit_clock_neg_q,
  output logic             lane_a_q,
  output logic             lane_b_q,
  output logic             word_frame_q,
  output logic             dither_enable_q,
  output logic             powered_down_q
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] smp_s_q, sclk_s_q, sen_s_q;
  logic [1:0] sdat_s_q, slp_s_q;
  always_ff @(posedge clk_sys)
  begin
    smp_s_q  <= {smp_s_q[1:0], sample_clock_pos};
    sclk_s_q <= {sclk_s_q[1:0], spi_clk};
    sen_s_q  <= {sen_s_q[1:0], spi_en_n};
    sdat_s_q <= {sdat_s_q[0], spi_data};
    slp_s_q  <= {slp_s_q[0], sleep_pin};
  end
  // edges look at stages 2 and 3 only
  wire samp_rise = smp_s_q[1] & ~smp_s_q[2];
  wire sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
  wire sen_low   = ~sen_s_q[1];
  wire sen_rise  = sen_s_q[1] & ~sen_s_q[2];
  wire sleep     = slp_s_q[1];

  // ----------------------------------------
  // serial programming port, write only
  // ----------------------------------------
  logic [23:0] sh_q;
  logic [4:0]  scnt_q;
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || !sen_low)
      scnt_q <= 5'h00;
    else if (sclk_rise && scnt_q != 5'(FRAME_BITS + 1))
      scnt_q <= scnt_q + 5'h01;
    if (sclk_rise && sen_low)
      sh_q <= {sh_q[22:0], sdat_s_q[1]};
  end
  // frames of the wrong length are dropped
  wire              wr_en    = sen_rise && scnt_q == 5'(FRAME_BITS);
  wire [7:0]        wr_addr  = sh_q[23:16];
  wire [15:0]       wr_data  = sh_q[15:0];
  wire              soft_rst = wr_en && wr_addr == REG_SOFT_RESET && wr_data[SOFT_RESET_BIT];
  wire              reg_rst  = !rstn || soft_rst;

  logic [15:0] pat_q, c1_q, c2_q;
  always_ff @(posedge clk_sys)
  begin
    if (reg_rst)                                        // [RULE8] [RULE16]
    begin
      dither_enable_q <= DITHER_RESET[DITHER_BIT];      // [RULE6]
      pat_q           <= PAT_RESET;
      c1_q            <= CODE_RESET;
      c2_q            <= CODE_RESET;
    end
    else if (wr_en)
    begin
      if (wr_addr == REG_DITHER)
        dither_enable_q <= wr_data[DITHER_BIT];         // [RULE7]
      if (wr_addr == REG_PAT_MODE)
        pat_q <= wr_data;
      if (wr_addr == REG_CODE1_LO)
        c1_q <= wr_data;
      if (wr_addr == REG_CODE2_LO)
        c2_q <= wr_data;
    end
  end

  // ----------------------------------------
  // pattern selection
  // ----------------------------------------
  wire two_code = pat_q[TWO_CODE_BIT] & ~pat_q[FIXED_CODE_BIT];   // [RULE9]
  wire fixed    = pat_q[FIXED_CODE_BIT] & ~pat_q[TWO_CODE_BIT];   // [RULE10]
  wire [11:0] code1 = {pat_q[CODE1_MSB_POS+1:CODE1_MSB_POS],
                       c1_q[15:CODE_LO_POS]};                     // [RULE11] [RULE12] [RULE13]
  wire [11:0] code2 = {pat_q[CODE2_MSB_POS+1:CODE2_MSB_POS],
                       c2_q[15:CODE_LO_POS]};                     // [RULE12] [RULE14]
  logic alt_q;
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || !two_code)
      alt_q <= 1'b0;
    else if (samp_rise)
      alt_q <= ~alt_q;                                  // [RULE9]
  end
  wire [11:0] push_word  = two_code ? (alt_q ? code2 : code1)
                         : fixed ? code1 : adc_data;    // [RULE10]
  wire        push_valid = samp_rise && !sleep && (two_code || fixed || adc_valid);

  // ----------------------------------------
  // two-entry buffer
  // ----------------------------------------
  // a full buffer refuses the word; core_ready_q tells the source
  logic [11:0]    mem [2];
  logic           wp_q, rp_q;
  logic [1:0]     cnt_q;
  lcp_ser_state_t st_q;
  wire            push = push_valid && cnt_q != 2'h2;
  wire            pop  = st_q == LCP_IDLE && cnt_q != 2'h0 && !sleep;
  wire [1:0]      cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || sleep)
    begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      wp_q  <= wp_q ^ push;
      rp_q  <= rp_q ^ pop;
      cnt_q <= cnt_d;
    end
    if (push)
      mem[wp_q] <= push_word;
  end
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      core_ready_q <= 1'b0;
    else
      core_ready_q <= !sleep && cnt_d != 2'h2;
  end

  // ----------------------------------------
  // two-lane serializer
  // ----------------------------------------
  // six edges per word leave the clock high again between words
  logic [5:0] sha_q, shb_q;
  logic [2:0] bits_q;
  wire  [11:0] rd_word = mem[rp_q];
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || sleep)                                 // [RULE5]
    begin
      st_q            <= LCP_IDLE;
      bit_clock_pos_q <= 1'b1;
      bit_clock_neg_q <= 1'b0;
      lane_a_q        <= 1'b0;
      lane_b_q        <= 1'b0;
      word_frame_q    <= 1'b0;
      bits_q          <= 3'h0;
    end
    else if (pop)
    begin
      st_q            <= LCP_SHIFT;
      bit_clock_pos_q <= 1'b0;                          // [RULE1]
      bit_clock_neg_q <= 1'b1;                          // [RULE2]
      lane_a_q        <= rd_word[11];
      lane_b_q        <= rd_word[5];
      sha_q           <= {rd_word[10:6], 1'b0};
      shb_q           <= {rd_word[4:0], 1'b0};
      word_frame_q    <= 1'b1;
      bits_q          <= 3'h1;
    end
    else if (st_q == LCP_SHIFT)
    begin
      if (bits_q == 3'(LANE_BITS))
      begin
        // clock is already back high; holding it keeps the next first edge falling [RULE1]
        st_q         <= LCP_IDLE;
        word_frame_q <= 1'b0;
        lane_a_q     <= 1'b0;
        lane_b_q     <= 1'b0;
      end
      else
      begin
        bit_clock_pos_q <= ~bit_clock_pos_q;
        bit_clock_neg_q <= bit_clock_pos_q;             // [RULE2]
        lane_a_q <= sha_q[5];
        lane_b_q <= shb_q[5];
        sha_q    <= {sha_q[4:0], 1'b0};
        shb_q    <= {shb_q[4:0], 1'b0};
        bits_q   <= bits_q + 3'h1;
      end
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      powered_down_q <= 1'b0;
    else
      powered_down_q <= sleep;                          // [RULE5]
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  first_edge_fall_a: assert property (pop |-> bit_clock_pos_q ##1 !bit_clock_pos_q) // [RULE1]
    else $error("bit clock did not fall first");
  clk_pair_inv_a: assert property ($past(rstn) |-> bit_clock_neg_q == !bit_clock_pos_q) // [RULE2]
    else $error("bit clock legs not complementary");
  sleep_entry_a: assert property (sleep |=> powered_down_q && bit_clock_pos_q && !word_frame_q) // [RULE5]
    else $error("sleep did not stop output");
  dither_reset_a: assert property ($past(!rstn) |-> dither_enable_q) // [RULE6]
    else $error("dither off after reset");
  dither_write_a: assert property (wr_en && wr_addr == REG_DITHER && !wr_data[0] && !soft_rst // [RULE7]
    |=> !dither_enable_q)
    else $error("dither write ignored");
  soft_reset_a: assert property (soft_rst |=> dither_enable_q && pat_q == 16'h0000) // [RULE8]
    else $error("reset command left registers");
  two_code_alt_a: assert property (samp_rise && two_code && $past(two_code) && !wr_en // [RULE9]
    |=> alt_q != $past(alt_q))
    else $error("two-code pattern did not alternate");
  fixed_code_a: assert property (push && fixed |-> push_word == code1) // [RULE10]
    else $error("fixed pattern wrong code");
  msb_field_a: assert property (wr_en && !soft_rst && wr_addr == REG_PAT_MODE // [RULE12]
    |=> code1[11:10] == $past(wr_data[1:0]) && code2[11:10] == $past(wr_data[3:2]))
    else $error("code msbs misplaced");
  code1_low_a: assert property (wr_en && !soft_rst && wr_addr == REG_CODE1_LO // [RULE13]
    |=> code1[9:0] == $past(wr_data[15:6]))
    else $error("first code low bits misplaced");
  code2_low_a: assert property (wr_en && !soft_rst && wr_addr == REG_CODE2_LO // [RULE14]
    |=> code2[9:0] == $past(wr_data[15:6]))
    else $error("second code low bits misplaced");
  normal_data_a: assert property ($past(!rstn) |-> !two_code && !fixed) // [RULE16]
    else $error("pattern active after reset");

  two_code_c: cover property (push && two_code ##[1:20] push && two_code);
  fixed_code_c: cover property (push && fixed);
  buffer_full_c: cover property (cnt_q == 2'h2);
  sleep_c: cover property ($rose(powered_down_q));
endmodule

// ===== verif/lcp_rx_model.sv
// deserializer model at the far side of the serial lanes
`timescale 1ns/1ns
module lcp_rx_model (
  input  wire logic        clk_sys,
  input  wire logic        frame,
  input  wire logic        lane_a,
  input  wire logic        lane_b,
  output logic [11:0]      word,
  output logic             word_stb
);
  logic [5:0] sh_a;
  logic [5:0] sh_b;
  int         n = 0;
  initial word_stb = 1'b0;
  // ----------------------------------------
  // capture
  // ----------------------------------------
  // aligns on the frame, never on a fixed latency
  // samples on the system clock, so either bit-clock polarity works
  always @(posedge clk_sys)
  begin
    word_stb <= 1'b0;
    if (frame === 1'b1)
    begin
      sh_a <= {sh_a[4:0], lane_a};
      sh_b <= {sh_b[4:0], lane_b};
      n    <= n + 1;
    end
    else
    begin
      if (n == 6)
      begin
        word     <= {sh_a, sh_b};
        word_stb <= 1'b1;
      end
      n <= 0;
    end
  end
endmodule

// ===== verif/tb.sv
// bench for the serial pattern output block
`timescale 1ns/1ns
module tb;
  import lcp_pkg::*;
  logic        clk_sys, rstn, sample_clock_pos, sleep_pin, spi_clk, spi_data, spi_en_n;
  logic        adc_valid, core_ready_q, bit_clock_pos_q, bit_clock_neg_q, lane_a_q, lane_b_q;
  logic        word_frame_q, dither_enable_q, powered_down_q, rx_stb, frame_d, clk_d;
  logic [11:0] adc_data, rx_word, c1, c2;
  logic [31:0] rng = 32'd89;
  logic [11:0] rxq[$];
  int          mismatches = 0;
  int          cmp_count = 0;
  lcp_pattern_out dut (.clk_sys, .rstn, .sample_clock_pos, .sleep_pin, .spi_clk, .spi_data,
    .spi_en_n, .adc_data, .adc_valid, .core_ready_q, .bit_clock_pos_q, .bit_clock_neg_q,
    .lane_a_q, .lane_b_q, .word_frame_q, .dither_enable_q, .powered_down_q);
  lcp_rx_model rx (.clk_sys, .frame(word_frame_q), .lane_a(lane_a_q), .lane_b(lane_b_q),
    .word(rx_word), .word_stb(rx_stb));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [11:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[11:0];
  endfunction
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // halves of 4 cycles keep clear of the 3-cycle sync delay
  task automatic spi_wr(input logic [7:0] a, input logic [15:0] d);
    logic [23:0] f;
    f = {a, d};
    @(negedge clk_sys) spi_en_n = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      spi_data = f[i];
      repeat (4) @(negedge clk_sys);
      spi_clk = 1'b1;
      repeat (4) @(negedge clk_sys);
      spi_clk = 1'b0;
    end
    repeat (4) @(negedge clk_sys);
    spi_en_n = 1'b1;
    repeat (8) @(negedge clk_sys);
  endtask
  // drain words in flight, then compare six against the mode model
  task automatic run(input int m);
    int k;
    int ph;
    logic [11:0] e;
    repeat (24) @(negedge clk_sys);
    rxq.delete();
    k = 0;
    while (rxq.size() < 6 && k < 400)
    begin
      @(negedge clk_sys);
      k++;
    end
    chk(12'(rxq.size()), 12'h006);
    ph = (m == 2 && rxq.size() > 0 && rxq[0] === c2) ? 1 : 0;
    for (int i = 0; i < rxq.size(); i++)
    begin
      e = (m == 1) ? c1 : (m == 2) ? (((i + ph) % 2) ? c2 : c1) : adc_data;
      chk(rxq[i], e);
    end
    $display("test mode %0d done", m);
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // clocks, capture, wire checks
  // ----------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial
  begin
    sample_clock_pos = 1'b0;
    #7;
    forever #160 sample_clock_pos = ~sample_clock_pos;
  end
  always @(posedge clk_sys) if (rx_stb === 1'b1) rxq.push_back(rx_word);
  always @(negedge clk_sys)
  begin
    if (rstn === 1'b1)
    begin
      chk({11'h0, bit_clock_neg_q}, {11'h0, ~bit_clock_pos_q});
      if (word_frame_q === 1'b1 && frame_d === 1'b0)
        chk({10'h0, clk_d, bit_clock_pos_q}, 12'h002);
    end
    frame_d = word_frame_q;
    clk_d   = bit_clock_pos_q;
  end
  initial
  begin
    #1000000;
    mismatches++;
    final_report();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    rstn = 1'b0; sleep_pin = 1'b0; spi_clk = 1'b0; spi_data = 1'b0; spi_en_n = 1'b1;
    adc_valid = 1'b1; adc_data = rnd(); c1 = 12'h000; c2 = 12'h000;
    repeat (4) @(negedge clk_sys);
    rstn = 1'b1;
    @(negedge clk_sys);
    chk({11'h0, dither_enable_q}, 12'h001);
    run(0);
    for (int m = 0; m < 4; m++)
    begin
      c1 = rnd();
      c2 = c1 ^ (rnd() | 12'h001);
      adc_data = rnd();
      spi_wr(REG_CODE1_LO, {c1[9:0], 6'h00});
      spi_wr(REG_CODE2_LO, {c2[9:0], 6'h00});
      spi_wr(REG_PAT_MODE, {10'h000, 2'(m), c2[11:10], c1[11:10]});
      run(m);
    end
    spi_wr(REG_DITHER, 16'h0000);
    chk({11'h0, dither_enable_q}, 12'h000);
    spi_wr(8'h40, 16'h0001);
    chk({11'h0, dither_enable_q}, 12'h000);
    spi_wr(REG_PAT_MODE, 16'h0010);
    spi_wr(REG_SOFT_RESET, 16'h0001);
    chk({11'h0, dither_enable_q}, 12'h001);
    run(0);
    sleep_pin = 1'b1;
    repeat (10) @(negedge clk_sys);
    chk({10'h0, powered_down_q, core_ready_q}, 12'h002);
    rxq.delete();
    repeat (40) @(negedge clk_sys);
    chk(12'(rxq.size()), 12'h000);
    sleep_pin = 1'b0;
    run(0);
    final_report();
  end
endmodule
